// [inc/apll_cfg_pkg.sv]
package apll_cfg_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_NUM_LO = 8'h00;
  localparam logic [7:0] OFS_NUM_HI = 8'h04;
  localparam logic [7:0] OFS_DEN = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_LIM = 8'h1C;
  // Widths.
  localparam int NUM_W = 48;
  localparam int DEN_W = 16;
  localparam int DIV_W = 10;
  localparam int LVL_W = 12;
  // Feedback divider range.
  localparam logic [9:0] DIV_MIN = 10'h07A;
  localparam logic [9:0] DIV_MAX = 10'h230;
  // Control field positions.
  localparam int CTRL_DBL_BIT = 0;
  localparam int CTRL_GPIO_BIT = 1;
  localparam int CTRL_DIV_LSB = 8;
  // Status bits.
  localparam int ST_LOL_BIT = 0;
  localparam int ST_BOOT_BIT = 1;
  localparam int ST_SRC_BIT = 2;
  localparam int ST_REJ_BIT = 3;
  // Interrupt bits.
  localparam int IRQ_LOL = 0;
  localparam int IRQ_REJ = 1;
  localparam int IRQ_W = 2;
  // Reset values.
  localparam logic [47:0] NUM_RST = 48'h0000_0000_0000;
  localparam logic [15:0] DEN_RST = 16'h0001;
  localparam logic [9:0] DIV_RST = 10'h07A;
  // Lock window half width in level units, the same for every divider.
  localparam logic [11:0] LIM_BASE = 12'h0040;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    BT_IDLE,
    BT_LOAD,
    BT_DONE
  } boot_e;
endpackage

// [logic/apll_cfg.sv]
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module apll_cfg (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_otp_en,
  input wire logic i_otp_valid,
  input wire logic [apll_cfg_pkg::NUM_W-1:0] i_otp_num,
  input wire logic [apll_cfg_pkg::DEN_W-1:0] i_otp_den,
  input wire logic [apll_cfg_pkg::DIV_W-1:0] i_otp_div,
  input wire logic i_otp_dbl,
  input wire logic i_eep_en,
  input wire logic i_eep_valid,
  input wire logic [apll_cfg_pkg::NUM_W-1:0] i_eep_num,
  input wire logic [apll_cfg_pkg::DEN_W-1:0] i_eep_den,
  input wire logic [apll_cfg_pkg::DIV_W-1:0] i_eep_div,
  input wire logic i_eep_dbl,
  input wire logic [apll_cfg_pkg::LVL_W-1:0] i_filt_level,
  output logic [apll_cfg_pkg::NUM_W-1:0] o_num,
  output logic [apll_cfg_pkg::DEN_W-1:0] o_den,
  output logic [apll_cfg_pkg::DIV_W-1:0] o_fb_div,
  output logic o_dbl_sel,
  output logic o_lol,
  output logic o_gpio_lol,
  output logic o_boot_done,
  output logic o_irq
);
  import apll_cfg_pkg::*;

  // The filter level comes from the analog side, so it is synchronised first.
  // A multi-bit level can be caught mid-change, so it is only taken once two
  // successive synchronised samples agree; this costs two cycles of alarm latency.
  logic [LVL_W-1:0] lvl_s1_r, lvl_s2_r, lvl_s3_r, lvl_r, lvl_nxt;
  always_ff @(posedge i_clk) begin
    lvl_s1_r <= i_filt_level;
    lvl_s2_r <= lvl_s1_r;
    lvl_s3_r <= lvl_s2_r;
    lvl_r <= lvl_nxt;
  end
  assign lvl_nxt = (lvl_s3_r == lvl_s2_r) ? lvl_s3_r : lvl_r;

  boot_e bt_r, bt_nxt;
  logic [NUM_W-1:0] num_r, num_nxt;
  logic [DEN_W-1:0] den_r, den_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic dbl_r, dbl_nxt, gpio_r, gpio_nxt, src_r, src_nxt;
  logic lol_r, lol_nxt, wait_r, wait_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [LVL_W-1:0] lo_lim, hi_lim, mid;
  logic acc, wr, rd, cap, div_ok, in_win, rej_ev;

  assign acc = (i_read | i_write) & wait_r;
  assign wr = i_write & ~wait_r & (bt_r == BT_DONE);
  assign rd = i_read & ~wait_r;
  assign cap = i_read & wait_r;
  assign div_ok = (i_writedata[CTRL_DIV_LSB +: DIV_W] >= DIV_MIN) &&
                  (i_writedata[CTRL_DIV_LSB +: DIV_W] <= DIV_MAX);
  assign rej_ev = wr && (i_address == OFS_CTRL) && i_byteenable[1] && !div_ok;

  // derived window
  // Centre scales with the divider, width stays LIM_BASE either side; a wider divider swings the filter further.
  always_comb begin
    mid = LVL_W'(div_r) + LVL_W'({dbl_r, 9'h000});
    lo_lim = mid - LIM_BASE;
    hi_lim = mid + LIM_BASE;
  end
  assign in_win = (lvl_r >= lo_lim) && (lvl_r <= hi_lim);

  always_comb begin
    bt_nxt = bt_r;
    num_nxt = num_r;
    den_nxt = den_r;
    div_nxt = div_r;
    dbl_nxt = dbl_r;
    gpio_nxt = gpio_r;
    src_nxt = src_r;
    imask_nxt = imask_r;
    ist_nxt = ist_r;
    rd_nxt = rd_r;
    // Waitrequest drops for one cycle per access, giving one wait state.
    wait_nxt = ~acc;
    lol_nxt = (bt_r == BT_DONE) ? !in_win : 1'b1;
    case (bt_r)
      BT_IDLE: begin
        bt_nxt = BT_LOAD;
      end
      BT_LOAD: begin
        if (i_otp_en && i_otp_valid) begin
          num_nxt = i_otp_num;
          den_nxt = i_otp_den;
          div_nxt = i_otp_div;
          dbl_nxt = i_otp_dbl;
          src_nxt = 1'b0;
        end else if (i_eep_en && i_eep_valid) begin
          num_nxt = i_eep_num;
          den_nxt = i_eep_den;
          div_nxt = i_eep_div;
          dbl_nxt = i_eep_dbl;
          src_nxt = 1'b1;
        end
        bt_nxt = BT_DONE;
      end
      BT_DONE: begin
        bt_nxt = BT_DONE;
      end
      default: begin
        bt_nxt = BT_IDLE;
      end
    endcase
    if (wr) begin
      case (i_address)
        OFS_NUM_LO: begin
          for (int b = 0; b < 4; b++) begin
            if (i_byteenable[b]) num_nxt[b*8 +: 8] = i_writedata[b*8 +: 8];
          end
        end
        OFS_NUM_HI: begin
          for (int b = 0; b < 2; b++) begin
            if (i_byteenable[b]) num_nxt[32+b*8 +: 8] = i_writedata[b*8 +: 8];
          end
        end
        OFS_DEN: begin
          for (int b = 0; b < 2; b++) begin
            if (i_byteenable[b]) den_nxt[b*8 +: 8] = i_writedata[b*8 +: 8];
          end
        end
        OFS_CTRL: begin
          if (i_byteenable[0]) begin
            dbl_nxt = i_writedata[CTRL_DBL_BIT];
            gpio_nxt = i_writedata[CTRL_GPIO_BIT];
          end
          if (i_byteenable[1] && div_ok) div_nxt = i_writedata[CTRL_DIV_LSB +: DIV_W];
        end
        OFS_IRQ_MASK: begin
          if (i_byteenable[0]) imask_nxt = i_writedata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    rd_nxt = BUS_ZERO;
    // Read data is captured while waitrequest is still high, so that it stands
    // in the cycle in which the master samples waitrequest low.
    if (cap) begin
      case (i_address)
        OFS_NUM_LO: rd_nxt = num_r[31:0];
        OFS_NUM_HI: rd_nxt = {16'h0000, num_r[47:32]};
        OFS_DEN: rd_nxt = {16'h0000, den_r};
        OFS_CTRL: rd_nxt = {14'h0000, div_r, 6'h00, gpio_r, dbl_r};
        OFS_STAT: rd_nxt = {28'h000_0000, rej_ev, src_r, bt_r == BT_DONE, lol_r};
        OFS_IRQ_STAT: rd_nxt = {30'h0000_0000, ist_r};
        OFS_IRQ_MASK: rd_nxt = {30'h0000_0000, imask_r};
        OFS_LIM: rd_nxt = {4'h0, hi_lim, 4'h0, lo_lim};
        default: rd_nxt = BUS_ZERO;
      endcase
    end
    // clear on read
    // Only the bits handed to the master are cleared; a bit set after capture survives.
    if (rd && (i_address == OFS_IRQ_STAT)) ist_nxt = ist_r & ~rd_r[IRQ_W-1:0];
    // Events set after the read clear, so a coincident event is kept.
    if (lol_nxt && !lol_r && bt_r == BT_DONE) ist_nxt[IRQ_LOL] = 1'b1;
    if (rej_ev) ist_nxt[IRQ_REJ] = 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bt_r <= BT_IDLE;
      num_r <= NUM_RST;
      den_r <= DEN_RST;
      div_r <= DIV_RST;
      dbl_r <= 1'b0;
      gpio_r <= 1'b0;
      src_r <= 1'b0;
      lol_r <= 1'b1;
      wait_r <= 1'b1;
      ist_r <= '0;
      imask_r <= '0;
      rd_r <= BUS_ZERO;
    end else begin
      bt_r <= bt_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      div_r <= div_nxt;
      dbl_r <= dbl_nxt;
      gpio_r <= gpio_nxt;
      src_r <= src_nxt;
      lol_r <= lol_nxt;
      wait_r <= wait_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign o_readdata = rd_r;
  assign o_waitrequest = wait_r;
  assign o_num = num_r;
  assign o_den = den_r;
  assign o_fb_div = div_r;
  assign o_dbl_sel = dbl_r;
  assign o_lol = lol_r;
  assign o_gpio_lol = lol_r & gpio_r;
  assign o_boot_done = (bt_r == BT_DONE);
  assign o_irq = |(ist_r & imask_r);

  // divider always legal after boot from host writes
  property div_keep_p;
    @(posedge i_clk) disable iff (!i_rst_n)
      rej_ev |=> (div_r == $past(div_r));
  endproperty
  div_range_a: assert property (div_keep_p) else $error("Illegal divider taken");
  rej_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rej_ev |=> ist_r[IRQ_REJ])
    else $error("Rejected divider not flagged");
  dbl_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr && i_address == OFS_CTRL && i_byteenable[0]) |=>
      dbl_r == $past(i_writedata[CTRL_DBL_BIT]))
    else $error("Doubler select not written");
  den_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr && i_address == OFS_DEN && i_byteenable == 4'hF) |=> den_r == $past(i_writedata[15:0]))
    else $error("Denominator not written");
  sequence boot_seq;
    bt_r == BT_IDLE ##1 bt_r == BT_LOAD;
  endsequence
  otp_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (boot_seq ##0 (i_otp_en && i_otp_valid)) |=> div_r == $past(i_otp_div))
    else $error("OTP contents not loaded");
  eep_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (boot_seq ##0 (!(i_otp_en && i_otp_valid) && i_eep_en && i_eep_valid)) |=>
      div_r == $past(i_eep_div))
    else $error("EEPROM contents not loaded");
  boot_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    boot_seq |=> bt_r == BT_DONE)
    else $error("Boot did not finish");
  host_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr && i_address == OFS_NUM_LO && i_byteenable == 4'hF) |=>
      num_r[31:0] == $past(i_writedata))
    else $error("Host write lost");
  sequence bus_req_s;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence bus_ack_s;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  bus_ack_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus_req_s |=> bus_ack_s)
    else $error("Access not answered in one wait state");
  lock_win_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bt_r == BT_DONE && in_win) |=> !lol_r)
    else $error("Locked level raised alarm");
  lol_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bt_r == BT_DONE && !in_win)[*2] |=> lol_r)
    else $error("Alarm dropped while unlocked");
  boot_lol_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bt_r != BT_DONE) |-> o_lol)
    else $error("Alarm low before boot finished");
  lol_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bt_r == BT_DONE && !lol_r && !in_win) |=> ist_r[IRQ_LOL])
    else $error("Loss of lock not latched");
  stat_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_read && o_waitrequest && i_address == OFS_STAT) |=>
      o_readdata[ST_LOL_BIT] == $past(lol_r))
    else $error("Status read lost the alarm");
  gpio_lol_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((wr && i_address == OFS_CTRL && i_byteenable[0]) ##1 lol_r) |->
      o_gpio_lol == $past(i_writedata[CTRL_GPIO_BIT]))
    else $error("GPIO alarm mismatch");
endmodule // apll_cfg

// [tb/boot_image_model.sv]
`timescale 1ns/1ps
module boot_image_model (
  input wire logic i_otp_bad,
  output logic o_otp_en,
  output logic o_otp_valid,
  output logic [47:0] o_otp_num,
  output logic [15:0] o_otp_den,
  output logic [9:0] o_otp_div,
  output logic o_otp_dbl,
  output logic o_eep_en,
  output logic o_eep_valid,
  output logic [47:0] o_eep_num,
  output logic [15:0] o_eep_den,
  output logic [9:0] o_eep_div,
  output logic o_eep_dbl
);
  // The memory stays enabled when its image is bad, so the device must check validity too.
  assign o_otp_en = 1'b1;
  assign o_otp_valid = !i_otp_bad;
  assign o_eep_en = 1'b1;
  assign o_eep_valid = 1'b1;
  // images in tuning range
  // Both images assume a 25 MHz crystal: 273 doubled and 544 direct land near 13.6 GHz.
  assign o_otp_num = 48'h0000_0000_0190;
  assign o_otp_den = 16'h0003;
  assign o_otp_div = 10'h111;
  assign o_otp_dbl = 1'b1;
  assign o_eep_num = 48'h0000_0000_0064;
  assign o_eep_den = 16'h0001;
  assign o_eep_div = 10'h220;
  assign o_eep_dbl = 1'b0;
endmodule // boot_image_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import apll_cfg_pkg::*;
  logic i_clk, i_rst_n, i_read, i_write, otp_bad;
  logic [7:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [11:0] i_filt_level;
  logic o_waitrequest, oe, ov, ob, ee, ev, eb, o_dbl_sel, o_lol, o_gpio_lol, o_boot_done, o_irq;
  logic [47:0] on, en, o_num;
  logic [15:0] od, ed, o_den;
  logic [9:0] ov_div, ev_div, o_fb_div;
  logic [9:0] divs [4] = '{10'h079, 10'h07A, 10'h231, 10'h230};
  logic [11:0] lvls [4] = '{12'h430, 12'h3E0, 12'h430, 12'h480};
  int num_errors = 0;
  int tests_run = 0;
  boot_image_model i_boot_image_model (.i_otp_bad(otp_bad), .o_otp_en(oe), .o_otp_valid(ov),
    .o_otp_num(on), .o_otp_den(od), .o_otp_div(ov_div), .o_otp_dbl(ob), .o_eep_en(ee),
    .o_eep_valid(ev), .o_eep_num(en), .o_eep_den(ed), .o_eep_div(ev_div), .o_eep_dbl(eb));
  apll_cfg i_apll_cfg (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_otp_en(oe), .i_otp_valid(ov),
    .i_otp_num(on), .i_otp_den(od), .i_otp_div(ov_div), .i_otp_dbl(ob), .i_eep_en(ee),
    .i_eep_valid(ev), .i_eep_num(en), .i_eep_den(ed), .i_eep_div(ev_div), .i_eep_dbl(eb),
    .i_filt_level(i_filt_level), .o_num(o_num), .o_den(o_den), .o_fb_div(o_fb_div),
    .o_dbl_sel(o_dbl_sel), .o_lol(o_lol), .o_gpio_lol(o_gpio_lol),
    .o_boot_done(o_boot_done), .o_irq(o_irq));
  always #20 i_clk = ~i_clk;
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; ends one edge after release so outputs have settled.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    i_address <= a;
    i_writedata <= d;
    i_read <= !w;
    i_write <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic rst(input logic bad);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    otp_bad <= bad;
    repeat (2) @(posedge i_clk);
    chk(o_fb_div, DIV_RST);
    chk(o_lol, 1'b1);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(o_boot_done, 1'b1);
  endtask
  task automatic wait_lol(input logic e);
    int n = 0;
    while (o_lol !== e && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_lol, e);
    chk(o_gpio_lol, e);
  endtask
  initial begin
    i_clk = 0;
    i_rst_n = 0;
    i_read = 0;
    i_write = 0;
    i_address = 8'h00;
    i_writedata = 32'h0000_0000;
    i_filt_level = 12'h000;
    otp_bad = 0;
    rst(1'b0);
    chk({o_num, o_den, o_fb_div, o_dbl_sel}, {on, od, ov_div, ob});
    rd(OFS_STAT, 32'h0000_0003);
    rst(1'b1);
    chk({o_num, o_den, o_fb_div, o_dbl_sel}, {en, ed, ev_div, eb});
    rd(OFS_STAT, 32'h0000_0007);
    chk({o_lol, o_gpio_lol}, 2'b10);
    wr(OFS_NUM_LO, 32'h89AB_CDEF);
    wr(OFS_NUM_HI, 32'h0000_4567);
    wr(OFS_DEN, 32'h0000_FFFF);
    chk({o_num, o_den}, 64'h4567_89AB_CDEF_FFFF);
    rd(OFS_NUM_HI, 32'h0000_4567);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {14'h0000, divs[i], 8'h03});
      chk(o_fb_div, i[0] ? divs[i] : (i == 0 ? ev_div : divs[i-1]));
      chk(o_irq, !i[0]);
      chk(o_dbl_sel, 1'b1);
      if (!i[0]) rd(OFS_IRQ_STAT, 32'h0000_0002);
      rd(OFS_IRQ_STAT, 32'h0000_0000);
    end
    rd(OFS_CTRL, 32'h0002_3003);
    rd(OFS_LIM, 32'h0470_03F0);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    // Window centre is 560 plus 512 for the doubler; 80 off is well outside.
    for (int i = 0; i < 4; i++) begin
      i_filt_level <= lvls[i];
      wait_lol(i[0]);
    end
    chk(o_irq, 1'b0);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    stop_test();
  end
endmodule // tb_top
